// ### spgd_pkg.sv
// shared constants for the single-pwm commutation gate enable block
package spgd_pkg;
	// ---------------------------------------------------------------
	// gate drive and sequencing
	// ---------------------------------------------------------------
	localparam int SEQ_STEP_NS = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SEQ_STEP_CYC = (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEVEL_W = 4;
	localparam logic [3:0] LEVEL_MAX = 4'hb;
	localparam logic [3:0] LEVEL_RST = 4'hb;
	localparam logic [2:0] GATE_OFF = 3'h0;

	typedef enum logic [1:0] {
		SEQ_OFF = 2'b00,
		SEQ_HIGH_UP = 2'b01,
		SEQ_LOW_UP = 2'b10,
		SEQ_RUN = 2'b11
	} spgd_seq_type;

	// per gate: 0 low, 1 high, 2 pwm
	typedef enum logic [1:0] {
		G_LO = 2'b00,
		G_HI = 2'b01,
		G_PWM = 2'b10
	} spgd_gsel_type;
endpackage

// ### spgd_sync.sv
// three-stage input synchroniser with agreement check
`timescale 1ns/1ns
`default_nettype none
module spgd_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} spgd_sync_st_type;
	spgd_sync_st_type st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		// a bit moves only once stages two and three agree
		for (int i = 0; i < W; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.q[i] = st_ff.s3[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.q;
endmodule
`default_nettype wire

// ### spgd_core.sv
// single-pwm commutation decoder with diode or active freewheel and gate supply sequencing
`timescale 1ns/1ns
`default_nettype none
module spgd_core #(
	parameter int STEP_CYC = spgd_pkg::SEQ_STEP_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pins from the controller
	input wire logic phase_a_high_input,
	input wire logic phase_a_low_input,
	input wire logic phase_b_high_input,
	input wire logic phase_b_low_input,
	input wire logic phase_c_high_input,
	input wire logic phase_c_low_input,
	input wire logic gate_enable,
	// serial settings
	input wire logic freewheel_select,
	input wire logic [3:0] hs_level_in,
	input wire logic [3:0] ls_level_in,
	// analog comparators
	input wire logic supply_above_crossover,
	input wire logic high_supply_under,
	input wire logic high_supply_over,
	input wire logic low_supply_under,
	// gate outputs
	output logic phase_a_high_gate,
	output logic phase_a_low_gate,
	output logic phase_b_high_gate,
	output logic phase_b_low_gate,
	output logic phase_c_high_gate,
	output logic phase_c_low_gate,
	// supply control and status
	output logic high_supply_en,
	output logic pump_doubler,
	output logic low_supply_en,
	output logic drivers_ready,
	output logic high_uv_flag,
	output logic high_ov_flag,
	output logic low_uv_flag,
	output logic [3:0] hs_level,
	output logic [3:0] ls_level
);
	// ---------------------------------------------------------------
	// input synchronisation
	// ---------------------------------------------------------------
	logic [10:0] pin_raw, pin_s;
	assign pin_raw = {phase_a_high_input, phase_a_low_input, phase_b_high_input,
		phase_b_low_input, phase_c_high_input, gate_enable, supply_above_crossover,
		high_supply_under, high_supply_over, low_supply_under, phase_c_low_input};

	spgd_sync #(.W(11)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.d(pin_raw),
		.q(pin_s)
	);

	logic pwm, en, above, huv, hov, luv;
	logic [3:0] code;
	assign pwm = pin_s[10];
	assign code = pin_s[9:6];
	assign en = pin_s[5];
	assign above = pin_s[4];
	assign huv = pin_s[3];
	assign hov = pin_s[2];
	assign luv = pin_s[1];

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		spgd_pkg::spgd_seq_type seq;
		logic [15:0] cnt;
		logic [5:0] gates;
		logic hs_en;
		logic ls_en;
		logic dbl;
		logic huv;
		logic hov;
		logic luv;
		logic rdy;
		logic [3:0] hs_lv;
		logic [3:0] ls_lv;
	} spgd_st_type;
	spgd_st_type st_ff, nxt_st;

	// decode: order a-high, a-low, b-high, b-low, c-high, c-low
	function automatic logic [11:0] decode(input logic [3:0] c, input logic fw);
		logic [11:0] s;
		s = '0;
		case (c)
			4'h6: s = {2'd2, 2'd0, 2'd0, 2'd1, 2'd0, 2'd0};
			4'h5: s = {2'd2, 2'd0, 2'd0, 2'd1, 2'd2, 2'd0};
			4'h4: s = {2'd0, 2'd0, 2'd0, 2'd1, 2'd2, 2'd0};
			4'hd: s = {2'd0, 2'd1, 2'd0, 2'd1, 2'd2, 2'd0};
			4'hc: s = {2'd0, 2'd1, 2'd0, 2'd0, 2'd2, 2'd0};
			4'h9: s = {2'd0, 2'd1, 2'd2, 2'd0, 2'd2, 2'd0};
			4'h8: s = {2'd0, 2'd1, 2'd2, 2'd0, 2'd0, 2'd0};
			4'hb: s = {2'd0, 2'd1, 2'd2, 2'd0, 2'd0, 2'd1};
			4'ha: s = {2'd0, 2'd0, 2'd2, 2'd0, 2'd0, 2'd1};
			4'h3: s = {2'd2, 2'd0, 2'd2, 2'd0, 2'd0, 2'd1};
			4'h2: s = {2'd2, 2'd0, 2'd0, 2'd0, 2'd0, 2'd1};
			4'h7: s = {2'd2, 2'd0, 2'd0, 2'd1, 2'd0, 2'd1};
			4'he: s = {2'd2, 2'd0, 2'd0, 2'd1, 2'd0, 2'd1};
			4'h0: s = '0;
			default: s = '0;
		endcase
		// active freewheel makes low gate the pwm complement
		if (fw) begin
			for (int p = 0; p < 3; p++) begin
				if (s[p*4+3 -: 2] == 2'd2) begin
					s[p*4+1 -: 2] = 2'd3;
				end
			end
		end
		return s;
	endfunction

	logic [11:0] sel;
	logic [5:0] gate_val;
	assign sel = decode(code, freewheel_select);

	// per-gate value from its selector
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_gate
			always_comb begin
				case (sel[g*2+1 -: 2])
					2'd0: gate_val[g] = 1'b0;
					2'd1: gate_val[g] = 1'b1;
					2'd2: gate_val[g] = pwm;
					default: gate_val[g] = ~pwm;
				endcase
			end
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		// levels follow settings in any state
		// separate high and low levels, clamped to eleven
		nxt_st.hs_lv = (hs_level_in > spgd_pkg::LEVEL_MAX) ? spgd_pkg::LEVEL_MAX : hs_level_in;
		nxt_st.ls_lv = (ls_level_in > spgd_pkg::LEVEL_MAX) ? spgd_pkg::LEVEL_MAX : ls_level_in;
		nxt_st.dbl = st_ff.hs_en & above;
		// supply faults, caught in run, sticky until gate enable restarts the sequence from off
		nxt_st.huv = st_ff.huv | (st_ff.seq == spgd_pkg::SEQ_RUN && huv);
		nxt_st.hov = st_ff.hov | (st_ff.seq == spgd_pkg::SEQ_RUN && hov);
		nxt_st.luv = st_ff.luv | (st_ff.seq == spgd_pkg::SEQ_RUN && luv);
		if (st_ff.cnt != '0) begin
			nxt_st.cnt = st_ff.cnt - 16'h0001;
		end
		case (st_ff.seq)
			spgd_pkg::SEQ_OFF: begin
				nxt_st.hs_en = 1'b0;
				nxt_st.ls_en = 1'b0;
				if (en) begin
					nxt_st.seq = spgd_pkg::SEQ_HIGH_UP;
					nxt_st.hs_en = 1'b1;
					nxt_st.cnt = 16'(STEP_CYC);
					nxt_st.huv = 1'b0;
					nxt_st.hov = 1'b0;
					nxt_st.luv = 1'b0;
				end
			end
			spgd_pkg::SEQ_HIGH_UP: begin
				if (st_ff.cnt == '0) begin
					nxt_st.seq = spgd_pkg::SEQ_LOW_UP;
					nxt_st.ls_en = 1'b1;
					nxt_st.cnt = 16'(STEP_CYC);
				end
			end
			spgd_pkg::SEQ_LOW_UP: begin
				if (st_ff.cnt == '0) begin
					nxt_st.seq = spgd_pkg::SEQ_RUN;
				end
			end
			spgd_pkg::SEQ_RUN: begin
			end
			default: nxt_st.seq = spgd_pkg::SEQ_OFF;
		endcase
		if (!en) begin
			nxt_st.seq = spgd_pkg::SEQ_OFF;
			nxt_st.hs_en = 1'b0;
			nxt_st.ls_en = 1'b0;
			nxt_st.dbl = 1'b0;
		end
		// gates held off on any supply fault or outside run
		// diode mode low gate stays off in pwm phases via decode
		// ready kept in its own flop so the pin is glitch free
		nxt_st.rdy = (nxt_st.seq == spgd_pkg::SEQ_RUN);
		if (nxt_st.seq == spgd_pkg::SEQ_RUN && !nxt_st.huv && !nxt_st.hov && !nxt_st.luv) begin
			nxt_st.gates = gate_val;
		end else begin
			nxt_st.gates = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_ff <= '{seq: spgd_pkg::SEQ_OFF, cnt: 16'h0000, gates: 6'h00, hs_en: 1'b0,
				ls_en: 1'b0, dbl: 1'b0, huv: 1'b0, hov: 1'b0, luv: 1'b0, rdy: 1'b0,
				hs_lv: spgd_pkg::LEVEL_RST, ls_lv: spgd_pkg::LEVEL_RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign phase_a_high_gate = st_ff.gates[5];
	assign phase_a_low_gate = st_ff.gates[4];
	assign phase_b_high_gate = st_ff.gates[3];
	assign phase_b_low_gate = st_ff.gates[2];
	assign phase_c_high_gate = st_ff.gates[1];
	assign phase_c_low_gate = st_ff.gates[0];
	assign high_supply_en = st_ff.hs_en;
	assign pump_doubler = st_ff.dbl;
	assign low_supply_en = st_ff.ls_en;
	assign drivers_ready = st_ff.rdy;
	assign high_uv_flag = st_ff.huv;
	assign high_ov_flag = st_ff.hov;
	assign low_uv_flag = st_ff.luv;
	assign hs_level = st_ff.hs_lv;
	assign ls_level = st_ff.ls_lv;
endmodule
`default_nettype wire

// ### spgd_chk.sv
// port checker for the single-pwm gate decoder
`timescale 1ns/1ns
`default_nettype none
module spgd_chk #(
	parameter int STEP_CYC = spgd_pkg::SEQ_STEP_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// inputs watched
	input wire logic gate_enable,
	input wire logic [3:0] hs_level_in,
	// gates
	input wire logic phase_a_high_gate,
	input wire logic phase_a_low_gate,
	input wire logic phase_b_high_gate,
	input wire logic phase_b_low_gate,
	// supplies and status
	input wire logic high_supply_en,
	input wire logic pump_doubler,
	input wire logic low_supply_en,
	input wire logic drivers_ready,
	input wire logic low_uv_flag,
	input wire logic [3:0] hs_level
);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// long enough to cover the input synchroniser
	sequence s_en_off;
		!gate_enable [*8];
	endsequence
	sequence s_low_up;
		$rose(low_supply_en);
	endsequence
	a_high_sup_off: assert property (s_en_off |-> !high_supply_en)
		else $error("high supply on while gate enable low");
	a_low_sup_off: assert property (s_en_off |-> !low_supply_en)
		else $error("low supply on while gate enable low");
	a_low_after_high: assert property (s_low_up |-> $past(high_supply_en, STEP_CYC))
		else $error("low supply came up too early");
	a_ready_needs_both: assert property (drivers_ready |-> low_supply_en && high_supply_en)
		else $error("ready without both supplies");
	a_doubler_only_on: assert property (pump_doubler |-> high_supply_en)
		else $error("doubler while pump off");
	a_no_low_with_high: assert property (!(phase_a_high_gate && phase_a_low_gate)
		&& !(phase_b_high_gate && phase_b_low_gate))
		else $error("high and low gate on together");
	a_fault_gates_off: assert property (low_uv_flag && $past(low_uv_flag) |->
		!(phase_a_high_gate || phase_a_low_gate || phase_b_high_gate || phase_b_low_gate))
		else $error("gate on with low supply fault");
	a_level_clamped: assert property ($past(rst_n) |->
		hs_level == (($past(hs_level_in) > 4'hb) ? 4'hb : $past(hs_level_in)))
		else $error("high side level not taken");
endmodule
`default_nettype wire

// ### spgd_ctl_model.sv
// controller model driving the pwm and commutation pins
`timescale 1ns/1ns
`default_nettype none
module spgd_ctl_model (
	// clock
	input wire logic ref_clk,
	// commands
	input wire logic pwm_lvl,
	input wire logic [3:0] code,
	// pins
	output logic phase_a_high_input,
	output logic [3:0] code_pins,
	output logic phase_c_low_input
);
	initial begin
		phase_a_high_input = 1'b0;
		code_pins = 4'h0;
		phase_c_low_input = 1'b0;
	end
	always @(posedge ref_clk) begin
		phase_a_high_input <= pwm_lvl;
		// dwell held high for the edge a step changes
		if (code[3:1] != code_pins[3:1]) begin
			code_pins <= {code[3:1], 1'b1};
		end else begin
			code_pins <= code;
		end
		phase_c_low_input <= !phase_c_low_input;
	end
endmodule
`default_nettype wire

// ### single_pwm_commutation_gate_enable_tb_top.sv
// self-checking bench for the single-pwm gate decoder
`timescale 1ns/1ns
`default_nettype none
module single_pwm_commutation_gate_enable_tb_top;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam int STEP_CYC = 4;
	localparam logic [11:0] TBL [16] = '{12'h000, 12'h000, 12'h801, 12'h881, 12'h018,
		12'h818, 12'h810, 12'h811, 12'h180, 12'h188, 12'h081, 12'h181, 12'h108, 12'h118,
		12'h811, 12'h000};
	logic ref_clk = 1'b0, rst_n = 1'b0, pwm_lvl = 1'b0, gate_enable = 1'b0;
	logic freewheel_select = 1'b0, supply_above_crossover = 1'b0, high_supply_under = 1'b0;
	logic high_supply_over = 1'b0, low_supply_under = 1'b0;
	logic [3:0] code = 4'h0, hs_level_in = 4'h0, ls_level_in = 4'h0, cp, hs_level, ls_level;
	logic phase_a_high_input, phase_c_low_input, high_supply_en, pump_doubler, low_supply_en;
	logic drivers_ready, high_uv_flag, high_ov_flag, low_uv_flag, phase_a_high_gate;
	logic phase_a_low_gate, phase_b_high_gate, phase_b_low_gate, phase_c_high_gate;
	logic phase_c_low_gate;
	logic [5:0] g;
	logic [11:0] exp_q[$];
	int errors = 0, checks = 0, cyc = 0, seed = 32'h5c4d6466;
	event take;
	assign g = {phase_a_high_gate, phase_a_low_gate, phase_b_high_gate, phase_b_low_gate,
		phase_c_high_gate, phase_c_low_gate};
	always #5 ref_clk = ~ref_clk;
	spgd_ctl_model u_ctl (.ref_clk, .pwm_lvl, .code, .phase_a_high_input, .code_pins(cp),
		.phase_c_low_input);
	spgd_core #(.STEP_CYC(STEP_CYC)) dut (.ref_clk, .rst_n, .phase_a_high_input,
		.phase_a_low_input(cp[3]), .phase_b_high_input(cp[2]), .phase_b_low_input(cp[1]),
		.phase_c_high_input(cp[0]), .phase_c_low_input, .gate_enable, .freewheel_select,
		.hs_level_in, .ls_level_in, .supply_above_crossover, .high_supply_under,
		.high_supply_over, .low_supply_under, .phase_a_high_gate, .phase_a_low_gate,
		.phase_b_high_gate, .phase_b_low_gate, .phase_c_high_gate, .phase_c_low_gate,
		.high_supply_en, .pump_doubler, .low_supply_en, .drivers_ready, .high_uv_flag,
		.high_ov_flag, .low_uv_flag, .hs_level, .ls_level);
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	function automatic logic [5:0] gates_for(input logic [3:0] c, input logic p);
		logic [11:0] t;
		t = TBL[c];
		for (int i = 0; i < 6; i++) gates_for[5 - i] = t[11 - 2 * i] ? p : t[10 - 2 * i];
	endfunction
	// gates settle after model, synchroniser and output flops
	task automatic apply(input logic [3:0] c, input logic p, input logic fw, input logic [5:0] e);
		@(posedge ref_clk);
		code <= c;
		pwm_lvl <= p;
		freewheel_select <= fw;
		exp_q.push_back({6'h00, e});
		repeat (12) @(posedge ref_clk);
		#1 -> take;
	endtask
	task automatic lv(input logic [3:0] h, input logic [3:0] l);
		@(posedge ref_clk);
		hs_level_in <= h;
		ls_level_in <= l;
		repeat (2) @(posedge ref_clk);
		#1;
		chk({4'h0, hs_level, ls_level}, {4'h0, (h > 4'hb) ? 4'hb : h, (l > 4'hb) ? 4'hb : l});
	endtask
	task automatic poke(input logic [3:0] f);
		@(posedge ref_clk);
		{supply_above_crossover, high_supply_under, high_supply_over, low_supply_under} <= f;
		repeat (10) @(posedge ref_clk);
		#1;
	endtask
	// no gate command until the supplies report ready
	task automatic power(input logic v);
		@(posedge ref_clk);
		gate_enable <= v;
		for (int i = 0; i < 60 && drivers_ready !== v; i++) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({9'h0, drivers_ready, high_supply_en, low_supply_en}, {9'h0, v, v, v});
	endtask
	// ---------------------------------------------------------------
	// monitor, timeout and main sequence
	// ---------------------------------------------------------------
	always @(take) chk({6'h00, g}, exp_q.pop_front());
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		lv(4'hc, 4'h3);
		chk({10'h0, high_supply_en, low_supply_en}, 12'h000);
		power(1'b1);
		for (int i = 0; i < 32; i++) apply(i[4:1], i[0], 1'b0, gates_for(i[4:1], i[0]));
		apply(4'h6, 1'b0, 1'b1, 6'b010100);
		apply(4'h6, 1'b1, 1'b1, 6'b100100);
		for (int i = 0; i < 4; i++) lv(4'($random(seed)), 4'($random(seed)));
		poke(4'h8);
		chk({11'h0, pump_doubler}, 12'h001);
		poke(4'h0);
		chk({11'h0, pump_doubler}, 12'h000);
		for (int f = 0; f < 3; f++) begin
			poke(4'h1 << f);
			chk({9'h0, high_uv_flag, high_ov_flag, low_uv_flag}, 12'h001 << f);
			chk({6'h0, g}, 12'h000);
			poke(4'h0);
			power(1'b0);
			power(1'b1);
		end
		wrap_up();
	end
endmodule
bind spgd_core spgd_chk #(.STEP_CYC(STEP_CYC)) u_chk (.ref_clk, .rst_n, .gate_enable,
	.hs_level_in, .phase_a_high_gate, .phase_a_low_gate, .phase_b_high_gate,
	.phase_b_low_gate, .high_supply_en, .pump_doubler, .low_supply_en, .drivers_ready,
	.low_uv_flag, .hs_level);
`default_nettype wire
